/* File: fsic_irq_controller.sv */
// Four-source vectored interrupt controller with control registers and return stack.
//
// Contract
// - Enables and flags live in control registers at addresses 0BH and 1EH.
// - Acknowledge clears master enable; later requests only set their flags.
// - Software re-enabling master and source inside a handler allows nesting.
// - No acknowledge while the stack is full; wait for a return.
// - Acknowledge pushes only the program counter, then branches to the vector.
// - Falling edge on external pin sets external flag, low register bit 4.
// - External acknowledge calls 04H, clears external flag and master enable.
// - Timer A or B overflow sets timer flag; acknowledge calls 10H, clears.
// - Time base tick sets bit 5; acknowledge calls 08H, clears.
// - Real-time clock tick sets bit 6; acknowledge calls 0CH, clears.
// - Interrupt return pops and sets master enable; plain return only pops.
// - Requests between two phase-two pulses are serviced at the later pulse; an external pin edge sampled one or two clocks before it waits one pulse more.
// - Priority: external, time base, real-time clock, then timer.
// - Low register bits 0-6 hold enables and flags; bit 7 reads 0.
// - Any of the four sources wakes the core from halt.
// - High register: timer enable bit 0, timer flag bit 4, rest zero.
// - A flag stays set until serviced or cleared by software.
// - Return stack has four levels, pointer at top after reset.
module fsic_irq_controller (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Data-memory access from the core.
  input wire fsic_pkg::fsic_memwr_s memWr,
  input wire logic [7:0] rdAddr,
  output logic [7:0] rdData,
  output logic rdHit,
  // Core sequencing.
  input wire logic phaseTwoPulse,
  input wire fsic_pkg::fsic_stackop_s stackOp,
  input wire logic [10:0] progCounter,
  input wire logic halted,
  // Request sources.
  input wire logic extIrqPinN,
  input wire logic timerAOverflow,
  input wire logic timerBOverflow,
  input wire logic timeBaseTick,
  input wire logic rtcTick,
  // Answers to the core.
  output logic irqCall,
  output logic [10:0] irqVector,
  output logic [10:0] returnAddr,
  output logic wakeUp,
  output logic stackFull
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and falling-edge detector for the external request.
  logic extSync1_r;
  logic extSync2_r;
  logic extPrev_r;
  logic extSync1_nxt;
  logic extSync2_nxt;
  logic extPrev_nxt;
  logic extFall;

  always_comb begin
    extSync1_nxt = extIrqPinN;
    extSync2_nxt = extSync1_r;
    extPrev_nxt = extSync2_r;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      extSync1_r <= 1'b1;
      extSync2_r <= 1'b1;
      extPrev_r <= 1'b1;
    end else begin
      extSync1_r <= extSync1_nxt;
      extSync2_r <= extSync2_nxt;
      extPrev_r <= extPrev_nxt;
    end
  end

  assign extFall = extPrev_r & ~extSync2_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register state.
  logic masterEn_r;
  logic [fsic_pkg::NUM_SRC-1:0] srcEn_r;
  logic [fsic_pkg::NUM_SRC-1:0] srcFlag_r;
  logic masterEn_nxt;
  logic [fsic_pkg::NUM_SRC-1:0] srcEn_nxt;
  logic [fsic_pkg::NUM_SRC-1:0] srcFlag_nxt;
  logic [fsic_pkg::NUM_SRC-1:0] hwSet;
  logic [fsic_pkg::NUM_SRC-1:0] ackOneHot;
  logic ackTake;
  logic wrLow;
  logic wrHigh;

  assign wrLow = memWr.wrEn && (memWr.addr == fsic_pkg::CTRL_LOW_ADDR);
  assign wrHigh = memWr.wrEn && (memWr.addr == fsic_pkg::CTRL_HIGH_ADDR);

  always_comb begin
    hwSet = '0;
    hwSet[fsic_pkg::SRC_EXT] = extFall;
    hwSet[fsic_pkg::SRC_TB] = timeBaseTick;
    hwSet[fsic_pkg::SRC_RTC] = rtcTick;
    hwSet[fsic_pkg::SRC_TMR] = timerAOverflow | timerBOverflow;
  end

  // Order inside the process gives the priorities: software write, then service
  // clear, then hardware set, so a new event is never lost to a clear.
  always_comb begin
    masterEn_nxt = masterEn_r;
    srcEn_nxt = srcEn_r;
    srcFlag_nxt = srcFlag_r;
    if (wrLow) begin
      masterEn_nxt = memWr.wrData[fsic_pkg::MASTER_EN_BIT];
      srcEn_nxt[fsic_pkg::SRC_EXT] = memWr.wrData[fsic_pkg::EXT_EN_BIT];
      srcEn_nxt[fsic_pkg::SRC_TB] = memWr.wrData[fsic_pkg::TB_EN_BIT];
      srcEn_nxt[fsic_pkg::SRC_RTC] = memWr.wrData[fsic_pkg::RTC_EN_BIT];
      srcFlag_nxt[fsic_pkg::SRC_EXT] = memWr.wrData[fsic_pkg::EXT_FLAG_BIT];
      srcFlag_nxt[fsic_pkg::SRC_TB] = memWr.wrData[fsic_pkg::TB_FLAG_BIT];
      srcFlag_nxt[fsic_pkg::SRC_RTC] = memWr.wrData[fsic_pkg::RTC_FLAG_BIT];
    end
    if (wrHigh) begin
      srcEn_nxt[fsic_pkg::SRC_TMR] = memWr.wrData[fsic_pkg::TMR_EN_BIT];
      srcFlag_nxt[fsic_pkg::SRC_TMR] = memWr.wrData[fsic_pkg::TMR_FLAG_BIT];
    end
    if (stackOp.retIrq) begin
      masterEn_nxt = 1'b1;
    end
    if (ackTake) begin
      masterEn_nxt = 1'b0;
      srcFlag_nxt = srcFlag_nxt & ~ackOneHot;
    end
    srcFlag_nxt = srcFlag_nxt | hwSet;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      masterEn_r <= fsic_pkg::CTRL_LOW_RESET[fsic_pkg::MASTER_EN_BIT];
      srcEn_r <= '0;
      srcFlag_r <= '0;
    end else begin
      masterEn_r <= masterEn_nxt;
      srcEn_r <= srcEn_nxt;
      srcFlag_r <= srcFlag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Arbitration at each phase-two pulse.
  function automatic logic [fsic_pkg::NUM_SRC-1:0] pickFirst(
    input logic [fsic_pkg::NUM_SRC-1:0] req
  );
    logic [fsic_pkg::NUM_SRC-1:0] grant;
    grant = '0;
    for (int i = fsic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        grant = '0;
        grant[i] = 1'b1;
      end
    end
    return grant;
  endfunction

  function automatic logic [10:0] vectorOf(input logic [fsic_pkg::NUM_SRC-1:0] grant);
    logic [10:0] v;
    v = fsic_pkg::TMR_VECTOR;
    if (grant[fsic_pkg::SRC_EXT]) begin
      v = fsic_pkg::EXT_VECTOR;
    end else if (grant[fsic_pkg::SRC_TB]) begin
      v = fsic_pkg::TB_VECTOR;
    end else if (grant[fsic_pkg::SRC_RTC]) begin
      v = fsic_pkg::RTC_VECTOR;
    end
    return v;
  endfunction

  logic [fsic_pkg::NUM_SRC-1:0] eligible;
  logic full;
  fsic_pkg::fsic_arb_e state_r;
  fsic_pkg::fsic_arb_e state_nxt;
  logic [10:0] vector_r;
  logic [10:0] vector_nxt;

  // Nesting falls out naturally: software setting the enables again inside a
  // handler makes the source eligible at the next pulse.
  assign eligible = srcFlag_r & srcEn_r & {fsic_pkg::NUM_SRC{masterEn_r & ~full}};
  assign ackOneHot = pickFirst(eligible);
  assign ackTake = phaseTwoPulse && (state_r != fsic_pkg::ARB_ACK) && (eligible != '0);

  always_comb begin
    state_nxt = state_r;
    vector_nxt = vector_r;
    case (state_r)
      fsic_pkg::ARB_IDLE, fsic_pkg::ARB_HOLD: begin
        if (ackTake) begin
          state_nxt = fsic_pkg::ARB_ACK;
          vector_nxt = vectorOf(ackOneHot);
        end else begin
          state_nxt = fsic_pkg::ARB_IDLE;
        end
      end
      fsic_pkg::ARB_ACK: begin
        state_nxt = fsic_pkg::ARB_HOLD;
      end
      default: begin
        state_nxt = fsic_pkg::ARB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= fsic_pkg::ARB_IDLE;
      vector_r <= '0;
    end else begin
      state_r <= state_nxt;
      vector_r <= vector_nxt;
    end
  end

  assign irqCall = (state_r == fsic_pkg::ARB_ACK);
  assign irqVector = vector_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Return stack; only the program counter is saved on acknowledge.
  logic stackPush;
  logic stackPop;

  assign stackPush = ackTake | stackOp.call;
  assign stackPop = stackOp.ret | stackOp.retIrq;

  fsic_stack #(
    .LEVELS(fsic_pkg::STACK_LEVELS),
    .WIDTH(fsic_pkg::PC_WIDTH)
  ) uStack (
    .clock(clock),
    .resetn(resetn),
    .push(stackPush),
    .pop(stackPop),
    .pushData(progCounter),
    .topData(returnAddr),
    .full(full),
    .depth()
  );

  assign stackFull = full;

  // A flag set before halt is already pending, so it gives no new wake event.
  assign wakeUp = halted & (hwSet != '0);

  ////////////////////////////////////////////////////////////////////////////////
  // Register read-back, registered so the data output comes from flip-flops.
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic rdHit_r;
  logic rdHit_nxt;

  always_comb begin
    rdData_nxt = 8'h00;
    rdHit_nxt = 1'b0;
    if (rdAddr == fsic_pkg::CTRL_LOW_ADDR) begin
      rdHit_nxt = 1'b1;
      rdData_nxt[fsic_pkg::MASTER_EN_BIT] = masterEn_r;
      rdData_nxt[fsic_pkg::EXT_EN_BIT] = srcEn_r[fsic_pkg::SRC_EXT];
      rdData_nxt[fsic_pkg::TB_EN_BIT] = srcEn_r[fsic_pkg::SRC_TB];
      rdData_nxt[fsic_pkg::RTC_EN_BIT] = srcEn_r[fsic_pkg::SRC_RTC];
      rdData_nxt[fsic_pkg::EXT_FLAG_BIT] = srcFlag_r[fsic_pkg::SRC_EXT];
      rdData_nxt[fsic_pkg::TB_FLAG_BIT] = srcFlag_r[fsic_pkg::SRC_TB];
      rdData_nxt[fsic_pkg::RTC_FLAG_BIT] = srcFlag_r[fsic_pkg::SRC_RTC];
    end else if (rdAddr == fsic_pkg::CTRL_HIGH_ADDR) begin
      rdHit_nxt = 1'b1;
      rdData_nxt[fsic_pkg::TMR_EN_BIT] = srcEn_r[fsic_pkg::SRC_TMR];
      rdData_nxt[fsic_pkg::TMR_FLAG_BIT] = srcFlag_r[fsic_pkg::SRC_TMR];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdData_r <= 8'h00;
      rdHit_r <= 1'b0;
    end else begin
      rdData_r <= rdData_nxt;
      rdHit_r <= rdHit_nxt;
    end
  end

  assign rdData = rdData_r;
  assign rdHit = rdHit_r;

endmodule

/* File: fsic_pkg.sv */
// Package of constants and carrier types for the four-source interrupt controller.
package fsic_pkg;

  // Data-memory addresses of the two control registers.
  localparam logic [7:0] CTRL_LOW_ADDR = 8'h0b;
  localparam logic [7:0] CTRL_HIGH_ADDR = 8'h1e;

  // Low control register field positions.
  localparam int MASTER_EN_BIT = 0;
  localparam int EXT_EN_BIT = 1;
  localparam int TB_EN_BIT = 2;
  localparam int RTC_EN_BIT = 3;
  localparam int EXT_FLAG_BIT = 4;
  localparam int TB_FLAG_BIT = 5;
  localparam int RTC_FLAG_BIT = 6;

  // High control register field positions.
  localparam int TMR_EN_BIT = 0;
  localparam int TMR_FLAG_BIT = 4;

  // Reset values of both registers.
  localparam logic [7:0] CTRL_LOW_RESET = 8'h00;
  localparam logic [7:0] CTRL_HIGH_RESET = 8'h00;

  // Service vectors, program-counter width and stack depth.
  localparam int PC_WIDTH = 11;
  localparam logic [10:0] EXT_VECTOR = 11'h004;
  localparam logic [10:0] TB_VECTOR = 11'h008;
  localparam logic [10:0] RTC_VECTOR = 11'h00c;
  localparam logic [10:0] TMR_VECTOR = 11'h010;
  localparam int STACK_LEVELS = 4;

  // Source index in priority order, highest first.
  localparam int SRC_EXT = 0;
  localparam int SRC_TB = 1;
  localparam int SRC_RTC = 2;
  localparam int SRC_TMR = 3;
  localparam int NUM_SRC = 4;

  // Data-memory access from the core.
  typedef struct packed {
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } fsic_memwr_s;

  // Stack-control commands from the core.
  typedef struct packed {
    logic call;
    logic ret;
    logic retIrq;
  } fsic_stackop_s;

  // Arbitration states.
  typedef enum logic [2:0] {
    ARB_IDLE = 3'b001,
    ARB_ACK = 3'b010,
    ARB_HOLD = 3'b100
  } fsic_arb_e;

endpackage

/* File: fsic_stack.sv */
// Four-level return-address stack with full indication.
module fsic_stack #(
  parameter int LEVELS = fsic_pkg::STACK_LEVELS,
  parameter int WIDTH = fsic_pkg::PC_WIDTH
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Push and pop.
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] pushData,
  // Status.
  output logic [WIDTH-1:0] topData,
  output logic full,
  output logic [$clog2(LEVELS+1)-1:0] depth
);

  localparam int DW = $clog2(LEVELS+1);

  // Elaboration-time check: a single level cannot tell empty from full.
  if (LEVELS < 2) begin : gBadLevels
    $error("fsic_stack needs at least two levels");
  end

  logic [WIDTH-1:0] mem_r [LEVELS];
  logic [WIDTH-1:0] mem_nxt [LEVELS];
  logic [DW-1:0] depth_r;
  logic [DW-1:0] depth_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // A push onto a full stack drops the oldest entry, so only the newest four survive.
  always_comb begin
    mem_nxt = mem_r;
    depth_nxt = depth_r;
    if (push) begin
      for (int i = LEVELS - 1; i > 0; i--) begin
        mem_nxt[i] = mem_r[i-1];
      end
      mem_nxt[0] = pushData;
      if (depth_r != DW'(LEVELS)) begin
        depth_nxt = depth_r + DW'(1);
      end
    end else if (pop) begin
      for (int i = 0; i < LEVELS - 1; i++) begin
        mem_nxt[i] = mem_r[i+1];
      end
      if (depth_r != '0) begin
        depth_nxt = depth_r - DW'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      depth_r <= '0;
      for (int i = 0; i < LEVELS; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      depth_r <= depth_nxt;
      mem_r <= mem_nxt;
    end
  end

  assign topData = mem_r[0];
  assign full = (depth_r == DW'(LEVELS));
  assign depth = depth_r;

endmodule

/* File: fsic_irq_chk.sv */
// Port-level checker for the four-source interrupt controller.
module fsic_irq_chk (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Core side.
  input wire fsic_pkg::fsic_stackop_s stackOp,
  input wire logic phaseTwoPulse,
  input wire logic [7:0] rdAddr,
  input wire logic [7:0] rdData,
  input wire logic rdHit,
  // Answers.
  input wire logic irqCall,
  input wire logic [10:0] irqVector,
  input wire logic stackFull
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_call_one; irqCall |=> !irqCall; endproperty
  a_call_one: assert property (p_call_one) else $error("call longer than one cycle");
  property p_call_p2; irqCall |-> $past(phaseTwoPulse); endproperty
  a_call_p2: assert property (p_call_p2) else $error("call without phase pulse");
  property p_vec_ok;
    irqCall |-> irqVector inside {11'h004, 11'h008, 11'h00c, 11'h010};
  endproperty
  a_vec_ok: assert property (p_vec_ok) else $error("bad vector");
  property p_vec_hold; !irqCall |-> $stable(irqVector); endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
  property p_full_block; phaseTwoPulse && stackFull |=> !irqCall; endproperty
  a_full_block: assert property (p_full_block) else $error("call on full stack");
  property p_pop_frees;
    stackFull && (stackOp.ret || stackOp.retIrq) && !stackOp.call |=> !stackFull;
  endproperty
  a_pop_frees: assert property (p_pop_frees) else $error("still full after pop");
  property p_unmapped;
    !(rdAddr inside {8'h0b, 8'h1e}) |=> rdData == 8'h00 && !rdHit;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_high_zero; rdHit && $past(rdAddr) == 8'h1e |-> (rdData & 8'hee) == 8'h00; endproperty
  a_high_zero: assert property (p_high_zero) else $error("high unused bits set");
endmodule
bind fsic_irq_controller fsic_irq_chk chk_u (.clock(clock), .resetn(resetn),
  .stackOp(stackOp), .phaseTwoPulse(phaseTwoPulse), .rdAddr(rdAddr), .rdData(rdData),
  .rdHit(rdHit), .irqCall(irqCall), .irqVector(irqVector), .stackFull(stackFull));

/* File: fsic_core_model.sv */
// Core sequencer stand-in: periodic phase-two pulses and a running program counter.
module fsic_core_model #(
  parameter int PERIOD = 4
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Sequencing.
  output logic phaseTwoPulse,
  output logic [10:0] progCounter
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Moving on the falling edge keeps the controller's sampling edge race free.
  always @(negedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt = 0;
      phaseTwoPulse = 1'b0;
      progCounter = 11'h000;
    end else begin
      cnt = (cnt + 1) % PERIOD;
      phaseTwoPulse = (cnt == 0);
      progCounter = progCounter + 11'h001;
    end
  end
endmodule

/* File: tb_top.sv */
// Self-checking testbench for the four-source interrupt controller.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, resetn, rdHit, phaseTwoPulse, halted, extIrqPinN, irqCall, wakeUp, stackFull;
  logic timerAOverflow, timerBOverflow, timeBaseTick, rtcTick;
  logic [7:0] rdAddr, rdData;
  logic [10:0] progCounter, irqVector, returnAddr, pcAtPulse;
  fsic_pkg::fsic_memwr_s memWr;
  fsic_pkg::fsic_stackop_s stackOp;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [10:0] vec [4] = '{11'h004, 11'h008, 11'h00c, 11'h010};
  logic [7:0] lowAfter [4] = '{8'h6e, 8'h4e, 8'h0e, 8'h0e};
  fsic_irq_controller dut_u (.clock(clock), .resetn(resetn), .memWr(memWr), .rdAddr(rdAddr),
    .rdData(rdData), .rdHit(rdHit), .phaseTwoPulse(phaseTwoPulse), .stackOp(stackOp),
    .progCounter(progCounter), .halted(halted), .extIrqPinN(extIrqPinN),
    .timerAOverflow(timerAOverflow), .timerBOverflow(timerBOverflow),
    .timeBaseTick(timeBaseTick), .rtcTick(rtcTick), .irqCall(irqCall), .irqVector(irqVector),
    .returnAddr(returnAddr), .wakeUp(wakeUp), .stackFull(stackFull));
  fsic_core_model core_u (.clock(clock), .resetn(resetn), .phaseTwoPulse(phaseTwoPulse),
    .progCounter(progCounter));
  // The counter value offered at a pulse is what an acknowledge must push.
  always @(posedge clock) begin
    if (phaseTwoPulse === 1'b1) begin
      pcAtPulse <= progCounter;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    memWr = '{1'b1, a, d};
    @(negedge clock);
    memWr.wrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    rdAddr = a;
    @(negedge clock);
    chk({3'h0, rdData}, {3'h0, exp});
    chk({10'h0, rdHit}, {10'h0, (a == fsic_pkg::CTRL_LOW_ADDR) || (a == fsic_pkg::CTRL_HIGH_ADDR)});
  endtask
  task automatic fire(input logic [3:0] src);
    @(negedge clock);
    {timerAOverflow, timerBOverflow, timeBaseTick, rtcTick} = src;
    @(negedge clock);
    {timerAOverflow, timerBOverflow, timeBaseTick, rtcTick} = 4'h0;
  endtask
  task automatic op(input fsic_pkg::fsic_stackop_s s);
    @(negedge clock);
    stackOp = s;
    @(negedge clock);
    stackOp = '0;
  endtask
  // Three pulse periods: the first call seen is compared, zero means none allowed.
  task automatic exp_call(input logic [10:0] exp);
    logic [10:0] got;
    got = 11'h000;
    repeat (12) begin
      @(negedge clock);
      if (irqCall === 1'b1 && got === 11'h000) begin
        got = irqVector;
        chk(returnAddr, pcAtPulse);
      end
    end
    chk(got, exp);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
  initial begin
    resetn = 1'b0;
    memWr = '0;
    stackOp = '0;
    rdAddr = 8'h00;
    halted = 1'b0;
    extIrqPinN = 1'b1;
    {timerAOverflow, timerBOverflow, timeBaseTick, rtcTick} = 4'h0;
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    rd(8'h0b, 8'h00);
    rd(8'h1e, 8'h00);
    wr(8'h0b, 8'hf0);
    rd(8'h0b, 8'h70);
    wr(8'h1e, 8'hff);
    rd(8'h1e, 8'h11);
    rd(8'h0a, 8'h00);
    wr(8'h0b, 8'h00);
    wr(8'h1e, 8'h00);
    $display("test registers done");
    extIrqPinN = 1'b0;
    fire(4'b0111);
    repeat (4) @(negedge clock);
    rd(8'h0b, 8'h70);
    rd(8'h1e, 8'h10);
    wr(8'h1e, 8'h11);
    wr(8'h0b, 8'h7f);
    for (int i = 0; i < 4; i++) begin
      exp_call(vec[i]);
      exp_call(11'h000);
      rd(8'h0b, lowAfter[i]);
      op(3'b001);
    end
    rd(8'h0b, 8'h0f);
    rd(8'h1e, 8'h01);
    $display("test priority done");
    repeat (4) op(3'b100);
    chk({10'h0, stackFull}, 11'h001);
    fire(4'b1000);
    exp_call(11'h000);
    op(3'b010);
    exp_call(11'h010);
    op(3'b010);
    rd(8'h0b, 8'h0e);
    wr(8'h0b, 8'h0f);
    fire(4'b0001);
    exp_call(11'h00c);
    $display("test stack done");
    @(negedge clock);
    halted = 1'b1;
    timeBaseTick = 1'b1;
    memWr = '{1'b1, 8'h0b, 8'h00};
    #1 chk({10'h0, wakeUp}, 11'h001);
    @(negedge clock);
    halted = 1'b0;
    timeBaseTick = 1'b0;
    memWr.wrEn = 1'b0;
    rd(8'h0b, 8'h20);
    $display("test wake done");
    finish_test();
  end
endmodule
